// ==== common/cfp_map.vh ====
// Constants of the fetch and execute core: register map, fields, reset values, timing
`ifndef CFP_MAP_VH
`define CFP_MAP_VH
`default_nettype none

// Register offsets on the bus (byte addresses)
`define CFP_REG_CTRL 4'h0
`define CFP_REG_PCIR 4'h4
`define CFP_REG_CORE 4'h8

// Control register fields
`define CFP_CTRL_RUN 0
`define CFP_CTRL_IRQEN 1
`define CFP_CTRL_SIZE_LO 2
`define CFP_CTRL_SIZE_HI 3
`define CFP_CTRL_RESET 4'h9

// Program space sizes selected by the size field
`define CFP_SIZE_1K 2'h0
`define CFP_SIZE_2K 2'h1
`define CFP_SIZE_4K 2'h2
`define CFP_MASK_1K 13'h03ff
`define CFP_MASK_2K 13'h07ff
`define CFP_MASK_4K 13'h0fff
`define CFP_MASK_8K 13'h1fff

// Program vectors
`define CFP_RESET_VECTOR 13'h0000
`define CFP_IRQ_VECTOR 13'h0004

// Special register offsets within every bank
`define CFP_SFR_INDIRECT 7'h00
`define CFP_SFR_PCL 7'h02
`define CFP_SFR_STATUS 7'h03
`define CFP_SFR_FSR 7'h04
`define CFP_SFR_PCLATH 7'h0a
`define CFP_SFR_TOP 7'h20
`define CFP_COMMON_BASE 7'h70

// Status byte fields
`define CFP_ST_C 0
`define CFP_ST_DC 1
`define CFP_ST_Z 2
`define CFP_ST_BANK_LO 5
`define CFP_ST_BANK_HI 6
`define CFP_ST_IRP 7

// Instruction classes in bits 13:12
`define CFP_CLS_FILE 2'h0
`define CFP_CLS_NOP 2'h1
`define CFP_CLS_JUMP 2'h2
`define CFP_CLS_LIT 2'h3

// ALU operation codes
`define CFP_OP_ADD 4'h0
`define CFP_OP_SUB 4'h1
`define CFP_OP_AND 4'h2
`define CFP_OP_OR 4'h3
`define CFP_OP_XOR 4'h4
`define CFP_OP_MOV 4'h5
`define CFP_OP_RLC 4'h6
`define CFP_OP_RRC 4'h7
`define CFP_OP_COM 4'h8
`define CFP_OP_INC 4'h9
`define CFP_OP_DEC 4'ha
`define CFP_OP_CLR 4'hb
`define CFP_OP_SWAP 4'hc
`define CFP_OP_MOVW 4'hd

// Timing: four phases per instruction cycle, oscillator 20 MHz, cycle 200 ns
`define CFP_PHASES 4
`define CFP_OSC_MHZ 20
`define CFP_CYCLE_NS 200

`default_nettype wire
`endif

// ==== design/cfp_alu.v ====
// Eight-bit arithmetic and logic unit of the core
`include "cfp_map.vh"
`default_nettype none
module cfp_alu (
   // Operands
   input wire [7:0] acc,
   input wire [7:0] opnd,
   input wire [3:0] op,
   input wire carry_in,
   // Result and flags
   output reg [7:0] result,
   output reg carry_out,
   output reg digit_carry_flag,
   output wire zero_out,
   output reg upd_c,
   output reg upd_dc,
   output reg upd_z
);
   reg [8:0] sum;
   reg [4:0] nib;

   always @* begin
      sum = 9'h000;
      nib = 5'h00;
      result = 8'h00;
      carry_out = carry_in;
      digit_carry_flag = 1'b0;
      upd_c = 1'b0;
      upd_dc = 1'b0;
      upd_z = 1'b1;
      case (op)
         `CFP_OP_ADD: begin
            sum = {1'b0, opnd} + {1'b0, acc};
            nib = {1'b0, opnd[3:0]} + {1'b0, acc[3:0]};
            result = sum[7:0];
            carry_out = sum[8];
            digit_carry_flag = nib[4];
            upd_c = 1'b1;
            upd_dc = 1'b1;
         end
         `CFP_OP_SUB: begin
            // Carry set means no borrow
            sum = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
            nib = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
            result = sum[7:0];
            carry_out = sum[8];
            digit_carry_flag = nib[4];
            upd_c = 1'b1;
            upd_dc = 1'b1;
         end
         `CFP_OP_AND: result = opnd & acc;
         `CFP_OP_OR: result = opnd | acc;
         `CFP_OP_XOR: result = opnd ^ acc;
         `CFP_OP_MOV: result = opnd;
         `CFP_OP_RLC: begin
            result = {opnd[6:0], carry_in};
            carry_out = opnd[7];
            upd_c = 1'b1;
            upd_z = 1'b0;
         end
         `CFP_OP_RRC: begin
            result = {carry_in, opnd[7:1]};
            carry_out = opnd[0];
            upd_c = 1'b1;
            upd_z = 1'b0;
         end
         `CFP_OP_COM: result = ~opnd;
         `CFP_OP_INC: result = opnd + 8'h01;
         `CFP_OP_DEC: result = opnd - 8'h01;
         `CFP_OP_CLR: result = 8'h00;
         `CFP_OP_SWAP: begin
            result = {opnd[3:0], opnd[7:4]};
            upd_z = 1'b0;
         end
         `CFP_OP_MOVW: begin
            result = acc;
            upd_z = 1'b0;
         end
         default: upd_z = 1'b0;
      endcase
   end

   assign zero_out = (result == 8'h00);
endmodule
`default_nettype wire

// ==== design/cfp_core.v ====
// Two-stage fetch and execute core with banked data memory and bus registers
`include "cfp_map.vh"
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module cfp_core #(
   parameter [1:0] SIZE_DEFAULT = `CFP_SIZE_4K
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Device pins
   input wire master_clear_n,
   input wire internal_oscillator_mode,
   input wire irq_req,
   output reg quarter_clock_output,
   // Program memory bus
   output reg [12:0] prog_addr,
   input wire [13:0] prog_data
);
   // Phase and pipeline state
   reg [1:0] ph_q;
   reg [12:0] program_counter_q;
   reg [13:0] instruction_latch_q;
   reg ir_ok_q;
   reg [7:0] w_q;
   reg [7:0] opnd_q;
   // Status and pointer registers
   reg c_q;
   reg dc_q;
   reg z_q;
   reg bank_select_low_q;
   reg bank_select_high_q;
   reg irp_q;
   reg [7:0] fsr_q;
   reg [4:0] pclath_q;
   // Bus-visible control
   reg [3:0] ctrl_q;
   // General purpose RAM, indexed by canonical nine-bit address
   reg [7:0] general_purpose_ram [0:511];

   wire core_rst = !aresetn || !master_clear_n;
   wire run = ctrl_q[`CFP_CTRL_RUN];
   wire phase_one = (ph_q == 2'h0);
   wire phase_two = (ph_q == 2'h1);
   wire phase_four = (ph_q == 2'h3);

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   wire [1:0] cls = instruction_latch_q[13:12];
   wire [3:0] op = instruction_latch_q[11:8];
   wire dest_file = instruction_latch_q[7];
   wire [6:0] file = instruction_latch_q[6:0];
   wire exec = ir_ok_q && run;
   wire is_file = exec && (cls == `CFP_CLS_FILE);
   wire is_lit = exec && (cls == `CFP_CLS_LIT);
   wire is_jump = exec && (cls == `CFP_CLS_JUMP);

   // high bit is the upper select
   wire [8:0] direct_addr = {bank_select_high_q, bank_select_low_q, file};
   wire [8:0] eff_addr = (file == `CFP_SFR_INDIRECT) ? {irp_q, fsr_q} : direct_addr;
   wire [6:0] eff_ofs = eff_addr[6:0];
   // low 32 of every bank are special
   wire eff_sfr = (eff_ofs < `CFP_SFR_TOP);
   // common block folds to bank zero
   wire eff_common = (eff_ofs >= `CFP_COMMON_BASE);
   wire [8:0] ram_idx = eff_common ? {2'b00, eff_ofs} : eff_addr;
   // bank three holds only the common block
   wire ram_ok = !eff_sfr && (eff_common || eff_addr[8:7] != 2'b11);

   // Program space mask for the selected size
   reg [12:0] pc_mask;
   always @* begin
      case (ctrl_q[`CFP_CTRL_SIZE_HI:`CFP_CTRL_SIZE_LO])
         `CFP_SIZE_1K: pc_mask = `CFP_MASK_1K;
         `CFP_SIZE_2K: pc_mask = `CFP_MASK_2K;
         `CFP_SIZE_4K: pc_mask = `CFP_MASK_4K;
         default: pc_mask = `CFP_MASK_8K;
      endcase
   end

   wire [7:0] status_byte = {irp_q, bank_select_high_q, bank_select_low_q, 2'b00, z_q, dc_q, c_q};

   // Data memory read mux
   reg [7:0] rd_data;
   always @* begin
      rd_data = 8'h00;
      if (ram_ok) begin
         rd_data = general_purpose_ram[ram_idx];
      end else if (eff_sfr) begin
         case (eff_ofs)
            `CFP_SFR_PCL: rd_data = program_counter_q[7:0];
            `CFP_SFR_STATUS: rd_data = status_byte;
            `CFP_SFR_FSR: rd_data = fsr_q;
            `CFP_SFR_PCLATH: rd_data = {3'b000, pclath_q};
            default: rd_data = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ALU
   wire [7:0] alu_res;
   wire alu_c;
   wire alu_dc;
   wire alu_z;
   wire upd_c;
   wire upd_dc;
   wire upd_z;
   // literal or file as second operand
   wire [7:0] alu_b = is_lit ? instruction_latch_q[7:0] : opnd_q;

   cfp_alu u_alu (
      .acc(w_q),
      .opnd(alu_b),
      .op(op),
      .carry_in(c_q),
      .result(alu_res),
      .carry_out(alu_c),
      .digit_carry_flag(alu_dc),
      .zero_out(alu_z),
      .upd_c(upd_c),
      .upd_dc(upd_dc),
      .upd_z(upd_z)
   );

   // Destination and counter change
   wire wr_file = is_file && (dest_file || op == `CFP_OP_MOVW);
   wire wr_w = is_lit || (is_file && !dest_file && op != `CFP_OP_MOVW);
   wire wr_pcl = wr_file && eff_sfr && eff_ofs == `CFP_SFR_PCL;
   wire wr_status = wr_file && eff_sfr && eff_ofs == `CFP_SFR_STATUS;
   wire take_irq = run && irq_req && ctrl_q[`CFP_CTRL_IRQEN] && !is_jump && !wr_pcl;
   wire pc_change = is_jump || wr_pcl || take_irq;

   ////////////////////////////////////////////////////////////////////////////
   // divide by four into phases
   always @(posedge aclk) begin
      if (core_rst) begin
         ph_q <= 2'h0;
      end else begin
         ph_q <= ph_q + 2'h1;
      end
   end

   // quarter-rate clock, high in phases three and four
   always @(posedge aclk) begin
      if (core_rst) begin
         quarter_clock_output <= 1'b0;
      end else begin
         quarter_clock_output <= internal_oscillator_mode && (ph_q[0] ^ ph_q[1]);
      end
   end

   // Fetch, counter and latch
   always @(posedge aclk) begin
      if (core_rst) begin
         program_counter_q <= `CFP_RESET_VECTOR;
         prog_addr <= `CFP_RESET_VECTOR;
         instruction_latch_q <= 14'h0000;
         ir_ok_q <= 1'b0;
      end else if (run) begin
         // address out and step in phase one
         if (phase_one) begin
            prog_addr <= program_counter_q & pc_mask;
            program_counter_q <= (program_counter_q + 13'h0001) & pc_mask;
         end
         if (phase_four) begin
            // whole word taken once per cycle
            // next word latched while current ends
            instruction_latch_q <= prog_data;
            // second cycle spent on the new target
            ir_ok_q <= !pc_change;
            if (take_irq) begin
               program_counter_q <= `CFP_IRQ_VECTOR;
            end else if (is_jump) begin
               program_counter_q <= {pclath_q[4:3], instruction_latch_q[10:0]} & pc_mask;
            end else if (wr_pcl) begin
               // counter low byte written as data
               program_counter_q <= {pclath_q, alu_res} & pc_mask;
            end
         end
      end
   end

   always @(posedge aclk) begin
      if (core_rst) begin
         opnd_q <= 8'h00;
      end else if (phase_two) begin
         opnd_q <= rd_data;
      end
   end

   // accumulator kept outside the data map
   always @(posedge aclk) begin
      if (core_rst) begin
         w_q <= 8'h00;
         c_q <= 1'b0;
         dc_q <= 1'b0;
         z_q <= 1'b0;
         bank_select_low_q <= 1'b0;
         bank_select_high_q <= 1'b0;
         irp_q <= 1'b0;
         fsr_q <= 8'h00;
         pclath_q <= 5'h00;
      end else if (phase_four && (is_file || is_lit)) begin
         if (wr_w) begin
            w_q <= alu_res;
         end
         if (wr_file && eff_sfr && eff_ofs == `CFP_SFR_FSR) begin
            fsr_q <= alu_res;
         end
         if (wr_file && eff_sfr && eff_ofs == `CFP_SFR_PCLATH) begin
            pclath_q <= alu_res[4:0];
         end
         if (wr_status) begin
            irp_q <= alu_res[`CFP_ST_IRP];
            bank_select_high_q <= alu_res[`CFP_ST_BANK_HI];
            bank_select_low_q <= alu_res[`CFP_ST_BANK_LO];
         end
         // flags take the operation's result over a status write
         c_q <= upd_c ? alu_c : (wr_status ? alu_res[`CFP_ST_C] : c_q);
         dc_q <= upd_dc ? alu_dc : (wr_status ? alu_res[`CFP_ST_DC] : dc_q);
         z_q <= upd_z ? alu_z : (wr_status ? alu_res[`CFP_ST_Z] : z_q);
      end
   end

   // general RAM write in phase four
   always @(posedge aclk) begin
      if (!core_rst && phase_four && wr_file && ram_ok) begin
         general_purpose_ram[ram_idx] <= alu_res;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = !s_axi_rvalid;

   // Write path: control is the only writable register
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= {SIZE_DEFAULT, 2'b01};
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            case (s_axi_awaddr)
               `CFP_REG_CTRL: begin
                  if (s_axi_wstrb[0]) begin
                     ctrl_q <= s_axi_wdata[3:0];
                  end
               end
               `CFP_REG_PCIR, `CFP_REG_CORE: s_axi_bresp <= 2'b00;
               default: s_axi_bresp <= 2'b10;
            endcase
         end
      end
   end

   // Read path: control, counter and latch, core state
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else begin
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
               `CFP_REG_CTRL: s_axi_rdata <= {28'h0000000, ctrl_q};
               `CFP_REG_PCIR: s_axi_rdata <= {2'b00, instruction_latch_q, 3'b000, program_counter_q};
               `CFP_REG_CORE: s_axi_rdata <= {15'h0000, ir_ok_q, status_byte, w_q};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== verification/cfp_core_sva.sv ====
// Checker of the fetch core: program link, quarter clock and bus handshakes
`default_nettype none
module cfp_core_sva (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Device pins and program link
   input wire logic master_clear_n,
   input wire logic internal_oscillator_mode,
   input wire logic quarter_clock_output,
   input wire logic [12:0] prog_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////////
   // Steps of a fetch cycle and of the quarter clock
   sequence s_addr_hold;
      $stable(prog_addr) [*3];
   endsequence
   sequence s_qclk_wave;
      quarter_clock_output ##1 !quarter_clock_output [*2] ##1 quarter_clock_output;
   endsequence
   AST_ADDR_HOLD: assert property (
      disable iff (!aresetn || !master_clear_n) $changed(prog_addr) |=> s_addr_hold)
      else $error("fetch address moved inside a cycle");
   AST_ADDR_CLEAR: assert property (!master_clear_n |=> prog_addr == 13'h0000)
      else $error("fetch address not zero under master clear");
   AST_QCLK_WAVE: assert property (
      disable iff (!aresetn || !master_clear_n || !internal_oscillator_mode)
      $rose(quarter_clock_output) |=> s_qclk_wave)
      else $error("quarter clock not two high of four");
   AST_QCLK_OFF: assert property (!internal_oscillator_mode [*2] |-> !quarter_clock_output)
      else $error("quarter clock runs with mode off");
   ////////////////////////////////////////////////////////////////////////////////
   // Bus handshakes
   AST_B_AFTER_W: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
      else $error("write response late");
   AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_R_AFTER_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
endmodule
bind cfp_core cfp_core_sva i_cfp_core_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .s_axi_rready, .master_clear_n, .internal_oscillator_mode, .quarter_clock_output, .prog_addr);
`default_nettype wire

// ==== verification/cfp_prog_mem.sv ====
// Program flash model: 8K words of 14 bits, word settles two clocks after the address
`default_nettype none
module cfp_prog_mem (
   // Clock
   input wire logic aclk,
   // Fetch port
   input wire logic [12:0] prog_addr,
   output var logic [13:0] prog_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [13:0] mem [0:8191];
   logic [12:0] last_q;
   initial begin
      prog_data = 14'h0000;
      last_q = 13'h0000;
   end
   // word per address
   // Garbage for one clock after the address moves, so an early sample shows
   always @(posedge aclk) begin
      last_q <= prog_addr;
      prog_data <= (prog_addr != last_q) ? ~prog_data : mem[prog_addr];
   end
endmodule
`default_nettype wire

// ==== verification/test_core_fetch_pipeline_memory_map.sv ====
// Testbench of the fetch core: registers, program flow, wrap, vectors, quarter clock
`include "cfp_map.vh"
`default_nettype none
module test_core_fetch_pipeline_memory_map;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} cfp_rexp_t;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, master_clear_n;
   logic internal_oscillator_mode, irq_req, quarter_clock_output;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [12:0] prog_addr, prev_pc;
   logic [13:0] prog_data;
   logic [7:0] v, d, st;
   int errors, checks_done;
   logic [1:0] exp_b[$];
   cfp_rexp_t exp_r[$];
   logic [12:0] exp_pc[$];
   cfp_core #(.SIZE_DEFAULT(`CFP_SIZE_4K)) i_cfp_core (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .master_clear_n, .internal_oscillator_mode,
      .irq_req, .quarter_clock_output, .prog_addr, .prog_data);
   cfp_prog_mem i_cfp_prog_mem (.aclk, .prog_addr, .prog_data);
   ////////////////////////////////////////////////////////////////////////////////
   // Compares and closing
   task check_data(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task check_resp(input logic [1:0] got, input logic [1:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: response %h expected %h", $time, got, exp);
      end
   endtask
   task tally_and_finish();
      $display("Checks %0d, errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Bus master, program loader and core clear
   task axi_write(input logic [3:0] a, input logic [31:0] w, input logic [1:0] r);
      @(posedge aclk);
      exp_b.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= w;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      // Each channel is released at the edge its own ready is seen
      while (s_axi_awvalid === 1'b1 || s_axi_wvalid === 1'b1) begin
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         @(posedge aclk);
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask
   task axi_read(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m, input logic [1:0] r);
      @(posedge aclk);
      exp_r.push_back('{x, m, r});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      while (s_axi_arready !== 1'b1) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask
   task load(input logic [13:0] w[$]);
      for (int i = 0; i < 8192; i++) i_cfp_prog_mem.mem[i] = 14'h1000;
      foreach (w[i]) i_cfp_prog_mem.mem[i] = w[i];
   endtask
   // Expected fetch addresses are noted while the core is held clear
   task clear_core(input logic [12:0] s[$]);
      @(posedge aclk);
      // clear held low, then released high
      master_clear_n <= 1'b0;
      repeat (3) @(posedge aclk);
      exp_pc = s;
      master_clear_n <= 1'b1;
      repeat (400) if (exp_pc.size() > 0) @(posedge aclk);
      check_data(32'(exp_pc.size()), 32'h0);
   endtask
   task count_qclk(input logic [31:0] exp);
      int k;
      k = 0;
      repeat (16) begin
         @(posedge aclk);
         k += (quarter_clock_output === 1'b1);
      end
      check_data(32'(k), exp);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, watchdog and output monitor
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      #300us;
      errors++;
      tally_and_finish();
   end
   always @(posedge aclk) begin
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1 && exp_b.size() > 0)
         check_resp(s_axi_bresp, exp_b.pop_front());
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && exp_r.size() > 0) begin
         check_data(s_axi_rdata & exp_r[0].m, exp_r[0].d);
         check_resp(s_axi_rresp, exp_r[0].r);
         void'(exp_r.pop_front());
      end
      if (prog_addr !== prev_pc && exp_pc.size() > 0)
         check_data({19'h0, prog_addr}, {19'h0, exp_pc.pop_front()});
      prev_pc <= prog_addr;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {irq_req, internal_oscillator_mode, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 42'h0;
      s_axi_wstrb = 4'hf;
      master_clear_n = 1'b1;
      prev_pc = 13'h0000;
      errors = 0;
      checks_done = 0;
      void'($urandom(32'h22ed));
      v = 8'($urandom());
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      internal_oscillator_mode <= 1'b1;
      axi_read(`CFP_REG_CTRL, 32'(`CFP_CTRL_RESET), 32'hffffffff, 2'h0);
      axi_read(4'hc, 32'h0, 32'h0, 2'h2);
      axi_write(4'hc, $urandom(), 2'h2);
      axi_write(`CFP_REG_PCIR, $urandom(), 2'h0);
      axi_read(`CFP_REG_CTRL, 32'(`CFP_CTRL_RESET), 32'hffffffff, 2'h0);
      count_qclk(32'h8);
      // Bank 1 subtract through the common alias, then a jump over a poison word
      load('{{6'h35, v}, 14'h0df1, 14'h3520, 14'h0d83, 14'h3501, 14'h0171, 14'h2008, 14'h35ff, 14'h2008});
      clear_core('{13'h1, 13'h2, 13'h3, 13'h4, 13'h5, 13'h6, 13'h7, 13'h8, 13'h9, 13'h8, 13'h9});
      d = v - 8'h01;
      st = {3'b001, 2'b00, d == 8'h00, v[3:0] != 4'h0, v != 8'h00};
      axi_read(`CFP_REG_CORE, {16'h0, st, d}, 32'h0000ffff, 2'h0);
      // Bank zero store, pointer load, then an indirect add into the accumulator
      load('{{6'h35, v}, 14'h0da5, 14'h3525, 14'h0d84, 14'h3503, 14'h0000, 14'h2006});
      clear_core('{13'h1, 13'h2, 13'h3, 13'h4, 13'h5, 13'h6, 13'h7, 13'h6, 13'h7});
      d = v + 8'h03;
      st = {5'b00000, d == 8'h00, v[3:0] > 4'hc, v > 8'hfc};
      axi_read(`CFP_REG_CORE, {16'h0, st, d}, 32'h0000ffff, 2'h0);
      // Small program spaces: jump to the word below the top and wrap to zero
      load('{14'h27fe});
      for (int n = 0; n < 2; n++) begin
         logic [12:0] m;
         m = (n == 0) ? `CFP_MASK_1K : `CFP_MASK_2K;
         axi_write(`CFP_REG_CTRL, 32'h1 | (32'(n) << 2), 2'h0);
         clear_core('{13'h1, m - 13'h1, m, 13'h0, 13'h1, m - 13'h1});
      end
      // Interrupt vector, first masked then enabled
      load('{14'h2000, 14'h1000, 14'h1000, 14'h1000, 14'h2004});
      irq_req <= 1'b1;
      clear_core('{13'h1, 13'h0, 13'h1});
      check_data({19'h0, prog_addr} & 32'h1ffe, 32'h0);
      axi_write(`CFP_REG_CTRL, 32'h3, 2'h0);
      repeat (40) @(posedge aclk);
      check_data({19'h0, prog_addr} & 32'h1ffe, 32'h4);
      axi_read(`CFP_REG_PCIR, {2'b00, 14'h2004, 16'h0004}, 32'h3fff_1ffe, 2'h0);
      irq_req <= 1'b0;
      internal_oscillator_mode <= 1'b0;
      repeat (2) @(posedge aclk);
      count_qclk(32'h0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
